// ===== rxdc_defines.svh
// offsets, field positions, reset values and counts for the rx line decoder
// How it works
// [R1] field value 01 selects Manchester decoding
// [R2] Manchester only in packet mode, never continuous
// [R3] chip pair 10 gives one, 01 zero
// [R4] Manchester delivers one bit per two chips
// [R5] preamble and sync pass as plain NRZ
// [R6] chip clock constant, unchanged at payload start
// [R7] queue holds decoded NRZ bytes after Manchester
// [R8] field value 10 selects de-whitening
// [R9] XOR payload and CRC with nine-stage LFSR
// [R10] de-whitening keeps one bit per chip
// [R11] queue holds de-whitened NRZ payload bytes
// [R12] host enables at most one method
// [R13] sync detection starts payload decoding automatically
// [R14] two CRC bytes stripped, never queued
// [R15] LFSR x^9+x^5+1, preset ones, per bit
// [R16] values 00 and 11 pass data unchanged
`ifndef RXDC_DEFINES_SVH
`define RXDC_DEFINES_SVH
`define RXDC_IDX_QUEUE    8'h00
`define RXDC_IDX_RATE_HI  8'h03
`define RXDC_IDX_RATE_LO  8'h04
`define RXDC_IDX_PKT1     8'h37
`define RXDC_IDX_PLEN     8'h60
`define RXDC_IDX_CTL      8'h61
`define RXDC_IDX_STAT     8'h62
`define RXDC_RST_RATE_HI  8'h1A
`define RXDC_RST_RATE_LO  8'h0B
`define RXDC_RST_PKT1     8'h10
`define RXDC_RST_PLEN     8'h40
`define RXDC_DC_MSB       6
`define RXDC_DC_LSB       5
`define RXDC_CTL_CONT     0
`define RXDC_ST_OVF       0
`define RXDC_ST_BAD       1
`define RXDC_ST_LVL_LSB   8
`define RXDC_CRC_BYTES    8'h02
`define RXDC_LFSR_SEED    9'h1FF
`define RXDC_LFSR_TAP     5
`define RXDC_LAST_BIT     3'h7
`endif

// ===== rxdc_pkg.sv
// types shared by the rx line decoder
package rxdc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PAY  = 2'b01,
    ST_CRC  = 2'b10
  } rxdc_state_e;

  typedef enum logic [1:0] {
    DC_NONE  = 2'b00,
    DC_MAN   = 2'b01,
    DC_WHITE = 2'b10,
    DC_RSVD  = 2'b11
  } rxdc_dc_e;

  typedef struct packed {
    rxdc_state_e state;
    logic [15:0] div;
    logic        half;
    logic        first;
    logic [7:0]  sh;
    logic [2:0]  nb;
    logic [7:0]  left;
    logic        pend_v;
    logic [7:0]  pend_d;
    logic [7:0]  rate_hi;
    logic [7:0]  rate_lo;
    logic [7:0]  pkt1;
    logic [7:0]  plen;
    logic        cont;
    logic        ovf;
    logic        bad;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rd_hit;
    logic        ne;
  } rxdc_top_s;
endpackage

// ===== rxdc_fifo_if.sv
// byte stream between the decoder and its receive queue
interface rxdc_fifo_if #(parameter int W = 8, parameter int LW = 5);
  logic          push_valid;
  logic          push_ready;
  logic [W-1:0]  push_data;
  logic          pop_valid;
  logic          pop_ready;
  logic [W-1:0]  pop_data;
  logic [LW-1:0] level;
  modport fill  (output push_valid, push_data, pop_ready,
                 input  push_ready, pop_valid, pop_data, level);
  modport store (input  push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data, level);
endinterface

// ===== rxdc_fifo.sv
// receive queue with a registered head word
module rxdc_fifo #(
  parameter int W  = 8,
  parameter int D  = 16,
  parameter int LW = 5
) (
  input  wire logic  clock_i,
  input  wire logic  rstn_i,
  rxdc_fifo_if.store q
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [LW-1:0]       cnt;
    logic                ov;
    logic [W-1:0]        od;
  } rxdc_fifo_s;
  rxdc_fifo_s s, n;

  // head register refills whenever it is empty or being taken
  always_comb begin
    n = s;
    if (q.pop_ready && s.ov) n.ov = 1'b0;
    if (!n.ov && s.cnt != '0) begin
      n.od  = s.mem[s.rp];
      n.ov  = 1'b1;
      n.rp  = AW'(s.rp + 1'b1);
      n.cnt = LW'(s.cnt - 1'b1);
    end
    if (q.push_valid && q.push_ready) begin
      n.mem[s.wp] = q.push_data;
      n.wp  = AW'(s.wp + 1'b1);
      n.cnt = LW'(n.cnt + 1'b1);
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) s <= '0;
    else s <= n;
  end

  assign q.push_ready = (s.cnt != LW'(D));  // honest full, seen upstream
  assign q.pop_valid  = s.ov;
  assign q.pop_data   = s.od;
  assign q.level      = LW'(s.cnt + LW'(s.ov));
endmodule // rxdc_fifo

// ===== rxdc_lfsr.sv
// nine-stage whitening sequence generator
`include "rxdc_defines.svh"
module rxdc_lfsr (
  input  wire logic clock_i,
  input  wire logic rstn_i,
  input  wire logic preset_i,
  input  wire logic step_i,
  output logic      bit_o
);
  typedef struct packed {
    logic [8:0] sr;
  } rxdc_lfsr_s;
  rxdc_lfsr_s s, n;

  // x^9 + x^5 + 1, one step per delivered bit
  always_comb begin
    n = s;
    if (preset_i) n.sr = `RXDC_LFSR_SEED;  // see [R15]
    else if (step_i)
      n.sr = {s.sr[0] ^ s.sr[`RXDC_LFSR_TAP], s.sr[8:1]};  // see [R15]
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) s <= '{sr: `RXDC_LFSR_SEED};
    else s <= n;
  end

  assign bit_o = s.sr[0];
endmodule // rxdc_lfsr

// ===== rxdc_decoder.sv
// rx line decoder: Manchester / de-whitening, APB registers, queue
`include "rxdc_defines.svh"
module rxdc_decoder #(
  parameter int DEPTH = 16
) (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        chip_i,
  input  wire logic        sync_found_i,
  output logic             data_ready_o
);
  rxdc_pkg::rxdc_top_s s, n;
  rxdc_fifo_if #(.W(8), .LW(5)) qb ();
  logic             lfsr_bit;
  logic             lfsr_preset;
  logic             lfsr_step;
  logic             tick;
  logic             fire;
  logic             bval;
  logic             byte_done;
  logic [15:0]      rate;
  rxdc_pkg::rxdc_dc_e mode;
  logic [7:0]       idx;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // word index of a byte address; upper bits must be clear to hit
  function automatic logic [7:0] reg_index(input logic [11:0] a);
    reg_index = a[9:2];
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    logic [7:0] i;
    i = reg_index(a);
    mapped = (a[11:10] == 2'h0) &&
             (i == `RXDC_IDX_QUEUE || i == `RXDC_IDX_RATE_HI ||
              i == `RXDC_IDX_RATE_LO || i == `RXDC_IDX_PKT1 ||
              i == `RXDC_IDX_PLEN || i == `RXDC_IDX_CTL ||
              i == `RXDC_IDX_STAT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sub-blocks

  rxdc_fifo #(.W(8), .D(DEPTH), .LW(5)) u_fifo (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .q       (qb.store)
  );

  rxdc_lfsr u_lfsr (
    .clock_i  (clock_i),
    .rstn_i   (rstn_i),
    .preset_i (lfsr_preset),
    .step_i   (lfsr_step),
    .bit_o    (lfsr_bit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // bus first, so a hardware flag set later in this process beats a clear
  always_comb begin
    n           = s;
    n.pready    = 1'b0;
    n.pslverr   = 1'b0;
    qb.pop_ready = 1'b0;
    idx         = reg_index(paddr_i);
    rate        = {s.rate_hi, s.rate_lo};
    mode        = rxdc_pkg::rxdc_dc_e'(s.pkt1[`RXDC_DC_MSB:`RXDC_DC_LSB]);
    fire        = 1'b0;
    bval        = chip_i;
    byte_done   = 1'b0;
    lfsr_preset = 1'b0;
    lfsr_step   = 1'b0;

    // apb setup: latch read data, answer in the first access cycle
    if (psel_i && !penable_i) begin
      n.pready  = 1'b1;
      n.pslverr = !mapped(paddr_i);
      n.prdata  = '0;
      n.rd_hit  = 1'b0;
      if (!pwrite_i && mapped(paddr_i)) begin
        if (idx == `RXDC_IDX_QUEUE) begin
          n.prdata[7:0] = qb.pop_valid ? qb.pop_data : 8'h00;
          n.rd_hit      = qb.pop_valid;  // pop only what was shown
        end else if (idx == `RXDC_IDX_RATE_HI) begin
          n.prdata[7:0] = s.rate_hi;
        end else if (idx == `RXDC_IDX_RATE_LO) begin
          n.prdata[7:0] = s.rate_lo;
        end else if (idx == `RXDC_IDX_PKT1) begin
          n.prdata[7:0] = s.pkt1;
        end else if (idx == `RXDC_IDX_PLEN) begin
          n.prdata[7:0] = s.plen;
        end else if (idx == `RXDC_IDX_CTL) begin
          n.prdata[`RXDC_CTL_CONT] = s.cont;
        end else begin
          n.prdata[`RXDC_ST_OVF] = s.ovf;
          n.prdata[`RXDC_ST_BAD] = s.bad;
          n.prdata[`RXDC_ST_LVL_LSB +: 5] = qb.level;
          n.prdata[`RXDC_ST_LVL_LSB + 8 +: 2] = s.state;
        end
      end
    end

    // apb access: writes land and the queue pops at the ready edge
    if (psel_i && penable_i && s.pready && !s.pslverr) begin
      if (!pwrite_i) begin
        qb.pop_ready = s.rd_hit && idx == `RXDC_IDX_QUEUE;  // see [R7]
      end else if (idx == `RXDC_IDX_RATE_HI) begin
        n.rate_hi = pwdata_i[7:0];
      end else if (idx == `RXDC_IDX_RATE_LO) begin
        n.rate_lo = pwdata_i[7:0];
      end else if (idx == `RXDC_IDX_PKT1) begin
        n.pkt1 = pwdata_i[7:0];
      end else if (idx == `RXDC_IDX_PLEN) begin
        n.plen = pwdata_i[7:0];
      end else if (idx == `RXDC_IDX_CTL) begin
        n.cont = pwdata_i[`RXDC_CTL_CONT];
      end else if (idx == `RXDC_IDX_STAT) begin
        if (pwdata_i[`RXDC_ST_OVF]) n.ovf = 1'b0;
        if (pwdata_i[`RXDC_ST_BAD]) n.bad = 1'b0;
      end
    end

    // chip timing free-runs; it is never realigned at the payload
    tick  = (rate == 16'h0000) || (s.div >= 16'(rate - 16'h0001));  // see [R6]
    n.div = tick ? 16'h0000 : 16'(s.div + 16'h0001);  // see [R6]

    // a byte the queue accepted frees the pending slot
    if (s.pend_v && qb.push_ready) n.pend_v = 1'b0;

    // idle covers preamble and sync: chips are not decoded there
    if (tick && s.state != rxdc_pkg::ST_IDLE) begin  // see [R5]
      if (mode == rxdc_pkg::DC_MAN) begin  // see [R1]
        if (!s.half) begin
          n.half  = 1'b1;
          n.first = chip_i;
        end else begin
          n.half = 1'b0;
          fire   = 1'b1;  // see [R4]
          bval   = s.first;  // 10 -> 1, 01 -> 0, see [R3]
          if (s.first == chip_i) n.bad = 1'b1;  // not a valid pair
        end
      end else if (mode == rxdc_pkg::DC_WHITE) begin  // see [R8]
        fire      = 1'b1;  // see [R10]
        bval      = chip_i ^ lfsr_bit;  // see [R9]
        lfsr_step = 1'b1;  // see [R15]
      end else begin
        fire = 1'b1;  // reserved value behaves as off, see [R16]
      end
    end

    // gather bits msb first; payload bytes queue, crc bytes do not
    if (fire) begin
      n.sh      = {s.sh[6:0], bval};
      n.nb      = 3'(s.nb + 3'h1);
      byte_done = (s.nb == `RXDC_LAST_BIT);
    end
    if (byte_done) begin
      n.left = 8'(s.left - 8'h01);
      if (s.state == rxdc_pkg::ST_PAY) begin
        if (n.pend_v) n.ovf = 1'b1;  // queue stalled too long
        n.pend_v = 1'b1;  // see [R7], see [R11]
        n.pend_d = {s.sh[6:0], bval};
        if (s.left == 8'h01) begin
          n.state = rxdc_pkg::ST_CRC;
          n.left  = `RXDC_CRC_BYTES;
        end
      end else if (s.left == 8'h01) begin
        n.state = rxdc_pkg::ST_IDLE;  // checksum dropped, see [R14]
      end
    end

    // sync restarts decoding from the very next chip
    if (sync_found_i && !s.cont) begin  // see [R13]
      lfsr_preset = 1'b1;  // see [R15]
      lfsr_step   = 1'b0;
      n.half      = 1'b0;
      n.nb        = 3'h0;
      if (s.plen == 8'h00) begin
        n.state = rxdc_pkg::ST_CRC;
        n.left  = `RXDC_CRC_BYTES;
      end else begin
        n.state = rxdc_pkg::ST_PAY;
        n.left  = s.plen;
      end
    end
    if (n.cont) n.state = rxdc_pkg::ST_IDLE;  // see [R2]
    n.ne = qb.pop_valid && !qb.pop_ready;
  end

  assign qb.push_valid = s.pend_v;
  assign qb.push_data  = s.pend_d;

  // single register stage for all state
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s         <= '0;
      s.rate_hi <= `RXDC_RST_RATE_HI;
      s.rate_lo <= `RXDC_RST_RATE_LO;
      s.pkt1    <= `RXDC_RST_PKT1;
      s.plen    <= `RXDC_RST_PLEN;
    end else begin
      s <= n;
    end
  end

  assign prdata_o     = s.prdata;
  assign pready_o     = s.pready;
  assign pslverr_o    = s.pslverr;
  assign data_ready_o = s.ne;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  a_apb_answer_next: assert property (  // bus answer timing
    psel_i && !penable_i |=> pready_o && (pslverr_o == !$past(mapped(paddr_i))))
    else $error("apb answer not in first access cycle");

  a_man_pair_one: assert property (  // see [R3]
    fire && mode == rxdc_pkg::DC_MAN && s.first && !chip_i |-> bval)
    else $error("manchester 10 did not give one");

  a_man_half_rate: assert property (  // see [R4]
    tick && s.state != rxdc_pkg::ST_IDLE && mode == rxdc_pkg::DC_MAN &&
    !s.half |-> !fire ##1 s.half)
    else $error("manchester fired on first chip");

  a_white_xor_bit: assert property (  // see [R9]
    fire && mode == rxdc_pkg::DC_WHITE |-> bval == (chip_i ^ lfsr_bit))
    else $error("de-whitening bit mismatch");

  a_white_full_rate: assert property (  // see [R10]
    tick && s.state != rxdc_pkg::ST_IDLE && mode == rxdc_pkg::DC_WHITE |->
    fire)
    else $error("de-whitening skipped a chip");

  a_sync_starts_pay: assert property (  // see [R13]
    sync_found_i && !s.cont && s.plen != 8'h00 && !n.cont |=>
    s.state == rxdc_pkg::ST_PAY && s.nb == 3'h0 && !s.half)
    else $error("sync did not start payload");

  a_crc_not_queued: assert property (  // see [R14]
    byte_done && s.state == rxdc_pkg::ST_CRC |=>
    s.pend_d == $past(s.pend_d) && !$rose(s.pend_v))
    else $error("checksum byte reached the queue");

  a_plain_passes: assert property (  // see [R16]
    fire && (mode == rxdc_pkg::DC_NONE || mode == rxdc_pkg::DC_RSVD) |->
    bval == chip_i)
    else $error("plain mode altered data");

  a_cont_no_decode: assert property (  // see [R2]
    s.cont |-> !fire && s.state == rxdc_pkg::ST_IDLE)
    else $error("decoding active in continuous mode");

  a_idle_no_bits: assert property (  // see [R5]
    s.state == rxdc_pkg::ST_IDLE |=> s.sh == $past(s.sh))
    else $error("bits produced outside payload");
endmodule // rxdc_decoder

// ===== rxdc_chip_src.sv
// chip source standing in for the demodulator and bit synchronizer
module rxdc_chip_src #(
  parameter int GAP = 3
) (
  input  wire logic clock_i,
  output logic      chip_o,
  output logic      sync_found_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic busy;
  int   hold;

  initial begin
    chip_o = 1'b0;
    sync_found_o = 1'b0;
    busy = 1'b0;
    hold = 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // between frames the line wanders, an idle decoder must ignore it
  always @(posedge clock_i) begin
    if (!busy) begin
      chip_o <= ~chip_o;
    end
  end

  // each chip stands hold clocks; hold must match the rate setting, and
  // any divider phase then still samples every chip once
  task automatic put(input logic c);
    @(posedge clock_i);
    sync_found_o <= 1'b0;
    chip_o <= c;
    repeat (hold - 1) @(posedge clock_i);
  endtask

  // sync pulse, then payload and two check bytes, line coded
  task automatic send_frame(input logic [7:0] pay[$], input logic [1:0] dc);
    logic [8:0] pn;
    logic       w;
    repeat (GAP) @(posedge clock_i);
    busy = 1'b1;
    sync_found_o <= 1'b1;
    pn = 9'h1FF;
    pay.push_back(8'h5A); // check byte stand-ins, never queued
    pay.push_back(8'hC3);
    foreach (pay[i]) begin
      for (int k = 7; k >= 0; k--) begin
        w = pay[i][k];
        if (dc == 2'b10) begin
          w = w ^ pn[0];
          pn = {pn[0] ^ pn[5], pn[8:1]};
        end
        put(w);
        if (dc == 2'b01) begin
          put(~w);
        end
      end
    end
    @(posedge clock_i);
    busy = 1'b0;
  endtask
endmodule // rxdc_chip_src

// ===== rxdc_decoder_tb.sv
// self-checking bench for the rx line decoder
`include "rxdc_defines.svh"
module rxdc_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock_i;
  logic        rstn_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        chip;
  logic        sync_found;
  logic        data_ready;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  exp_q[$];
  int          num_errors;
  int          checks;

  rxdc_decoder #(.DEPTH(16)) uut (
    .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .chip_i(chip), .sync_found_i(sync_found),
    .data_ready_o(data_ready)
  );

  rxdc_chip_src #(.GAP(3)) src (
    .clock_i(clock_i), .chip_o(chip), .sync_found_o(sync_found)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  always #25 clock_i = ~clock_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; pready is taken at the rising edge, as the slave
  // sees it, and the request stands until then; a hang ends by watchdog
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    while (pready !== 1'b1) begin
      @(posedge clock_i);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp,
                       input logic xerr);
    apb(1'b0, idx, 32'h00000000);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, xerr});
  endtask

  // program size and method, then let the partner send one frame
  task automatic frame(input logic [1:0] dc, input int n);
    logic [7:0] q[$];
    q = {};
    for (int i = 0; i < n; i++) begin
      q.push_back(8'(i * 37 + 92));
    end
    apb(1'b1, `RXDC_IDX_PLEN, 32'(n));
    apb(1'b1, `RXDC_IDX_PKT1, {25'h0, dc, 5'h10});
    src.send_frame(q, dc);
    repeat (6) @(posedge clock_i);
    exp_q = q;
  endtask

  task automatic summarize();
    $display("checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    summarize();
  end

  initial begin
    clock_i = 1'b0;
    rstn_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    num_errors = 0;
    checks = 0;
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    // reset values, unmapped index, queue port not writable
    rdchk(`RXDC_IDX_RATE_HI, 32'h0000001A, 1'b0);
    rdchk(`RXDC_IDX_RATE_LO, 32'h0000000B, 1'b0);
    rdchk(`RXDC_IDX_PKT1, 32'h00000010, 1'b0);
    rdchk(`RXDC_IDX_STAT, 32'h00000000, 1'b0);
    rdchk(8'h05, 32'h00000000, 1'b1);
    apb(1'b1, `RXDC_IDX_QUEUE, 32'h000000FF);
    rdchk(`RXDC_IDX_QUEUE, 32'h00000000, 1'b0);
    // one clock per chip keeps the partner in step with the ticks
    apb(1'b1, `RXDC_IDX_RATE_HI, 32'h00000000);
    apb(1'b1, `RXDC_IDX_RATE_LO, 32'h00000001);
    rdchk(`RXDC_IDX_RATE_LO, 32'h00000001, 1'b0);
    // every method code, checking that the check bytes never arrive
    for (int m = 0; m < 4; m++) begin
      frame(2'(m), 3);
      foreach (exp_q[i]) begin
        rdchk(`RXDC_IDX_QUEUE, {24'h0, exp_q[i]}, 1'b0);
      end
      rdchk(`RXDC_IDX_STAT, 32'h00000000, 1'b0);
      chk({31'h0, data_ready}, 32'h00000000);
    end
    // continuous mode: Manchester frame must leave the queue empty
    apb(1'b1, `RXDC_IDX_CTL, 32'h00000001);
    frame(2'b01, 2);
    rdchk(`RXDC_IDX_STAT, 32'h00000000, 1'b0);
    apb(1'b1, `RXDC_IDX_CTL, 32'h00000000);
    // 17 bytes fit (16 stored plus the head register), the 18th waits in
    // the pending slot and the 19th overwrites it
    frame(2'b00, 19);
    chk({31'h0, data_ready}, 32'h00000001);
    rdchk(`RXDC_IDX_STAT, 32'h00001101, 1'b0);
    for (int i = 0; i < 17; i++) begin
      rdchk(`RXDC_IDX_QUEUE, {24'h0, exp_q[i]}, 1'b0);
    end
    rdchk(`RXDC_IDX_QUEUE, {24'h0, exp_q[18]}, 1'b0);
    apb(1'b1, `RXDC_IDX_STAT, 32'h00000001);
    rdchk(`RXDC_IDX_STAT, 32'h00000000, 1'b0);
    rdchk(`RXDC_IDX_QUEUE, 32'h00000000, 1'b0);
    chk({31'h0, data_ready}, 32'h00000000);
    // equal chip pairs under Manchester flag a bad pair; bit = first chip
    apb(1'b1, `RXDC_IDX_PLEN, 32'h00000001);
    apb(1'b1, `RXDC_IDX_PKT1, 32'h00000030);
    exp_q = {8'hFF};
    src.send_frame(exp_q, 2'b00);
    repeat (40) @(posedge clock_i);
    rdchk(`RXDC_IDX_QUEUE, 32'h000000F3, 1'b0);
    rdchk(`RXDC_IDX_STAT, 32'h00000002, 1'b0);
    apb(1'b1, `RXDC_IDX_STAT, 32'h00000002);
    rdchk(`RXDC_IDX_STAT, 32'h00000000, 1'b0);
    // two clocks per chip: the divider paces decoding, partner holds chips
    apb(1'b1, `RXDC_IDX_RATE_LO, 32'h00000002);
    src.hold = 2;
    frame(2'b10, 2);
    foreach (exp_q[i]) begin
      rdchk(`RXDC_IDX_QUEUE, {24'h0, exp_q[i]}, 1'b0);
    end
    rdchk(`RXDC_IDX_STAT, 32'h00000000, 1'b0);
    summarize();
  end
endmodule // rxdc_decoder_tb
